// file: design/screen_block_regs.svh
/*
 Register indices, field positions and reset values of the
 screen-block layout registers.
 Assumes byte addressing on a 32-bit Avalon-MM bus, one word per register.
*/
`ifndef SCREEN_BLOCK_REGS_SVH
`define SCREEN_BLOCK_REGS_SVH

// Register indices; the byte address is four times the index
`define IDX_BLOCK_TWO_LINE_COUNT 18'h08010
`define IDX_BLOCK_THREE_START_LOW 18'h08011
`define IDX_BLOCK_THREE_START_HIGH 18'h08012
`define IDX_BLOCK_FOUR_START_LOW 18'h08013
`define IDX_BLOCK_FOUR_START_HIGH 18'h08014

// Field layout of a start-address high register
`define UPDATE_ENABLE_BIT 7
`define START_HIGH_MSB 6

// Reset values
`define RESET_BYTE 8'h00
`define RESET_START 15'h0000
`define RESET_WORD 32'h00000000

`endif

// file: design/screen_block_pkg.sv
/*
 Types shared by the screen-block register modules.
 Assumes nothing of its surroundings.
*/
package screen_block_pkg;
    typedef logic [7:0] line_count_type;
    typedef logic [14:0] start_addr_type;
    typedef enum logic {rd_idle, rd_answer} read_state_type;
endpackage

// file: design/start_addr_if.sv
/*
 Carrier between the register file and one start-address holder.
 Assumes a single clock shared by both ends.
*/
`timescale 1ns/10ps
interface start_addr_if;
    import screen_block_pkg::*;
    logic wr_low;
    logic wr_high;
    logic [7:0] wdata;
    logic [7:0] low;
    logic [7:0] high;
    start_addr_type addr;
    logic pending;
    modport regfile (output wr_low, output wr_high, output wdata, input low, input high, input addr, input pending);
    modport holder (input wr_low, input wr_high, input wdata, output low, output high, output addr, output pending);
endinterface

// file: design/start_addr_holder.sv
/*
 One screen-block start address: low and high byte registers and the address
 that the display function sees.
 Assumes write strobes are one-cycle pulses on clk_in and never both at once.
*/
`timescale 1ns/10ps
`include "screen_block_regs.svh"
module start_addr_holder
    import screen_block_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic smooth_scroll_in,
    start_addr_if.holder port
);
    logic [7:0] low;
    logic [7:0] high;
    start_addr_type addr;
    logic pending;
    wire update_enable = port.wr_high ? port.wdata[`UPDATE_ENABLE_BIT] : high[`UPDATE_ENABLE_BIT];
    wire [`START_HIGH_MSB:0] next_high_part = port.wr_high ? port.wdata[`START_HIGH_MSB:0] : high[`START_HIGH_MSB:0];
    wire want_apply = port.wr_high || pending;
    // An indirect update waits for smooth scrolling rather than being lost
    wire allow_apply = !update_enable || smooth_scroll_in;
    wire do_apply = want_apply && allow_apply;
    wire next_pending = want_apply && !allow_apply;
    start_addr_type next_addr;
    assign next_addr = do_apply ? {next_high_part, low} : addr;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            low <= `RESET_BYTE;
            high <= `RESET_BYTE;
            addr <= `RESET_START;
            pending <= 1'b0;
        end
        else
        begin
            if (port.wr_low)
                low <= port.wdata;
            if (port.wr_high)
                high <= port.wdata;
            addr <= next_addr;
            pending <= next_pending;
        end
    end

    assign port.low = low;
    assign port.high = high;
    assign port.addr = addr;
    assign port.pending = pending;

    a_low_write_holds: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        port.wr_low && !pending |=> $stable(addr))
        else $error("start address moved on a low-byte write");
    a_direct_apply: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        port.wr_high && !port.wdata[`UPDATE_ENABLE_BIT] |=> addr == {high[`START_HIGH_MSB:0], low})
        else $error("direct high-byte write not applied");
    a_indirect_waits: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        port.wr_high && port.wdata[`UPDATE_ENABLE_BIT] && !smooth_scroll_in |=> pending && $stable(addr))
        else $error("indirect update applied without smooth scroll");
    a_pending_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pending && smooth_scroll_in && !port.wr_high && !port.wr_low
        |=> !pending && addr == {high[`START_HIGH_MSB:0], low})
        else $error("pending update not released under smooth scroll");
endmodule // start_addr_holder

// file: design/screen_block_layout.sv
/*
 Screen-block layout registers: block-two line count and the start addresses
 of blocks three and four, behind an Avalon-MM slave with waitrequest.
 Assumes block_one_lines_in and smooth_scroll_in come from logic on clk_in.
*/
// What this block does
// - Block-two field holds line count minus one
// - Block-three address is high[6:0] over low[7:0]
// - Block-four high: address bits 14-8, bit7 update-enable
// - Address changes only after high byte written
// - Block-two field sets block-two displayed lines
// - Block-three lines are min of blocks one, two
`timescale 1ns/10ps
`include "screen_block_regs.svh"
module screen_block_layout
    import screen_block_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [17:0] address_in,
    input wire logic read_in,
    input wire logic write_in,
    input wire logic [31:0] writedata_in,
    input wire logic [3:0] byteenable_in,
    output logic [31:0] readdata_out,
    output logic waitrequest_out,
    input wire logic [7:0] block_one_lines_in,
    input wire logic smooth_scroll_in,
    output logic [7:0] block_two_lines_out,
    output logic [8:0] block_two_line_total_out,
    output logic [7:0] block_three_lines_out,
    output logic [14:0] block_three_start_out,
    output logic [14:0] block_four_start_out,
    output logic block_three_pending_out,
    output logic block_four_pending_out
);
    line_count_type block_two_lines;
    line_count_type block_three_lines;
    read_state_type read_state;
    read_state_type next_read_state;
    logic [31:0] readdata;
    logic [31:0] next_readdata;

    start_addr_if block_three_start();
    start_addr_if block_four_start();

    // Decode of word index; low two address bits are ignored on a word bus
    wire [17:0] word_index = {2'b00, address_in[17:2]};
    wire hit_two = word_index == `IDX_BLOCK_TWO_LINE_COUNT;
    wire hit_three_low = word_index == `IDX_BLOCK_THREE_START_LOW;
    wire hit_three_high = word_index == `IDX_BLOCK_THREE_START_HIGH;
    wire hit_four_low = word_index == `IDX_BLOCK_FOUR_START_LOW;
    wire hit_four_high = word_index == `IDX_BLOCK_FOUR_START_HIGH;
    // Registers are a byte wide; only lane 0 carries them
    wire write_lane0 = write_in && !read_in && byteenable_in[0];
    wire [7:0] wbyte = writedata_in[7:0];

    assign block_three_start.wr_low = write_lane0 && hit_three_low;
    assign block_three_start.wr_high = write_lane0 && hit_three_high;
    assign block_three_start.wdata = wbyte;
    assign block_four_start.wr_low = write_lane0 && hit_four_low;
    assign block_four_start.wr_high = write_lane0 && hit_four_high;
    assign block_four_start.wdata = wbyte;

    start_addr_holder u_block_three
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .smooth_scroll_in(smooth_scroll_in),
        .port(block_three_start.holder)
    );

    start_addr_holder u_block_four
    (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .smooth_scroll_in(smooth_scroll_in),
        .port(block_four_start.holder)
    );

    // Both counts are stored minus one, so the smaller field gives the smaller block
    wire [7:0] next_block_three_lines = (block_one_lines_in < block_two_lines) ?
        block_one_lines_in : block_two_lines;

    // Read mux; unmapped words read as zero, writes to them are dropped
    wire [7:0] read_byte = hit_two ? block_two_lines :
        hit_three_low ? block_three_start.low :
        hit_three_high ? block_three_start.high :
        hit_four_low ? block_four_start.low :
        hit_four_high ? block_four_start.high : `RESET_BYTE;

    // Reads answer one cycle late so that read data come from a flip-flop
    always_comb
    begin
        next_read_state = rd_idle;
        next_readdata = readdata;
        case (read_state)
            rd_idle:
            begin
                if (read_in && !write_in)
                begin
                    next_read_state = rd_answer;
                    next_readdata = {24'h000000, read_byte};
                end
            end
            rd_answer:
                next_read_state = rd_idle;
            default:
                next_read_state = rd_idle;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            read_state <= rd_idle;
            readdata <= `RESET_WORD;
        end
        else
        begin
            read_state <= next_read_state;
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            block_two_lines <= `RESET_BYTE;
            block_three_lines <= `RESET_BYTE;
        end
        else
        begin
            if (write_lane0 && hit_two)
                block_two_lines <= wbyte;
            block_three_lines <= next_block_three_lines;
        end
    end

    // Writes never wait; a read waits exactly one cycle
    assign waitrequest_out = read_in && !write_in && (read_state == rd_idle);
    assign readdata_out = readdata;
    assign block_two_lines_out = block_two_lines;
    assign block_two_line_total_out = {1'b0, block_two_lines} + 9'h001;
    assign block_three_lines_out = block_three_lines;
    // The holders only ever move after a high-byte write, so a host that breaks
    // the low-then-high order sees a mixed address
    assign block_three_start_out = block_three_start.addr;
    assign block_four_start_out = block_four_start.addr;
    assign block_three_pending_out = block_three_start.pending;
    assign block_four_pending_out = block_four_start.pending;

    // Line counts
    a_two_lines_write: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_two |=> block_two_lines_out == $past(wbyte))
        else $error("block-two line count not stored");
    a_lane_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_in && !read_in && !byteenable_in[0] && hit_two |=> $stable(block_two_lines_out))
        else $error("block-two line count changed without lane 0 enabled");
    a_two_lines_total: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        block_two_line_total_out == {1'b0, block_two_lines_out} + 9'h001)
        else $error("block-two line total is not field plus one");
    a_three_lines_min: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ##1 block_three_lines_out == (($past(block_one_lines_in) < $past(block_two_lines_out)) ?
        $past(block_one_lines_in) : $past(block_two_lines_out)))
        else $error("block-three line count is not the smaller of blocks one and two");

    // Start addresses as the display function sees them
    a_three_start_join: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_three_high && !wbyte[`UPDATE_ENABLE_BIT]
        |=> block_three_start_out == {$past(wbyte[6:0]), block_three_start.low})
        else $error("block-three start address not joined from high and low");
    a_four_start_join: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_four_high && !wbyte[`UPDATE_ENABLE_BIT]
        |=> block_four_start_out == {$past(wbyte[6:0]), block_four_start.low})
        else $error("block-four start address not joined from high and low");
    a_three_low_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_three_low && !block_three_pending_out |=> $stable(block_three_start_out))
        else $error("block-three address moved on a low-byte write");
    a_four_low_only: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_four_low && !block_four_pending_out |=> $stable(block_four_start_out))
        else $error("block-four address moved on a low-byte write");
    a_four_indirect_waits: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_lane0 && hit_four_high && wbyte[`UPDATE_ENABLE_BIT] && !smooth_scroll_in
        |=> block_four_pending_out && $stable(block_four_start_out))
        else $error("block-four indirect update applied without smooth scroll");
    a_four_scroll_release: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        block_four_pending_out && smooth_scroll_in && !block_four_start.wr_low && !block_four_start.wr_high
        |=> !block_four_pending_out)
        else $error("block-four pending update not released under smooth scroll");
    a_three_scroll_direct: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        block_three_start.wr_high && wbyte[`UPDATE_ENABLE_BIT] && smooth_scroll_in
        |=> !block_three_pending_out && block_three_start_out == {$past(wbyte[6:0]), block_three_start.low})
        else $error("block-three indirect update not applied during smooth scroll");

    // Register bus
    // A read answers from the flip-flop in the cycle after it is taken
    a_read_one_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        read_in && !write_in && read_state == rd_idle |-> waitrequest_out ##1 (!read_in || !waitrequest_out))
        else $error("read not answered after one wait cycle");
    a_write_no_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        write_in && !read_in |-> !waitrequest_out)
        else $error("write was stalled");
    a_idle_no_wait: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !read_in |-> !waitrequest_out)
        else $error("waitrequest raised with no read pending");
    a_read_data_match: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        read_in && !write_in && hit_two && read_state == rd_idle && !$past(write_in)
        |=> readdata_out == {24'h000000, $past(block_two_lines_out)})
        else $error("block-two readback wrong");
    a_three_low_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        read_in && !write_in && hit_three_low && read_state == rd_idle
        |=> readdata_out == {24'h000000, $past(block_three_start.low)})
        else $error("block-three low byte readback wrong");
    a_four_high_readback: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        read_in && !write_in && hit_four_high && read_state == rd_idle
        |=> readdata_out == {24'h000000, $past(block_four_start.high)})
        else $error("block-four high byte readback wrong");
endmodule // screen_block_layout

// file: verif/host_master.sv
/*
 Host side model: an Avalon-MM master that issues register reads and writes.
 Assumes a slave on clk_in that answers through waitrequest.
*/
`timescale 1ns/10ps
module host_master
(
    input wire logic clk_in,
    input wire logic waitrequest_in,
    input wire logic [31:0] readdata_in,
    output logic [17:0] address_out,
    output logic read_out,
    output logic write_out,
    output logic [31:0] writedata_out,
    output logic [3:0] byteenable_out
);
    initial
    begin
        address_out <= 18'h00000;
        read_out <= 1'b0;
        write_out <= 1'b0;
        writedata_out <= 32'h00000000;
        byteenable_out <= 4'h0;
    end

    // Released address and write-data lines show the inverse (byteenable keeps its value), so a slave latching stale values is caught
    task automatic bus_write(input logic [17:0] addr, input logic [7:0] data, input logic [3:0] be);
        @(posedge clk_in);
        address_out <= addr;
        writedata_out <= {24'h000000, data};
        byteenable_out <= be;
        write_out <= 1'b1;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        write_out <= 1'b0;
        address_out <= ~addr;
        writedata_out <= ~{24'h000000, data};
    endtask

    task automatic bus_read(input logic [17:0] addr, output logic [31:0] data);
        @(posedge clk_in);
        address_out <= addr;
        byteenable_out <= 4'hf;
        read_out <= 1'b1;
        do @(posedge clk_in); while (waitrequest_in !== 1'b0);
        data = readdata_in;
        read_out <= 1'b0;
        address_out <= ~addr;
    endtask

    // Low byte always goes first; the high byte commits the address, or leaves it pending if its bit 7 is set while smooth scroll is off
    task automatic write_start(input logic [17:0] low_addr, input logic [7:0] low, input logic [7:0] high);
        bus_write(low_addr, low, 4'h1);
        bus_write(low_addr + 18'h00004, high, 4'h1);
    endtask
endmodule // host_master

// file: verif/screen_block_layout_bench.sv
/*
 Self-checking bench for the screen-block layout registers.
 Assumes the host model drives the bus; the bench drives the side inputs.
*/
`timescale 1ns/10ps
module screen_block_layout_bench
    import screen_block_pkg::*;
;
    logic clk_in;
    logic reset_n_in;
    logic [7:0] block_one_lines;
    logic smooth_scroll;
    wire logic [17:0] address;
    wire logic read;
    wire logic write;
    wire logic [31:0] writedata;
    wire logic [3:0] byteenable;
    wire logic [31:0] readdata;
    wire logic waitrequest;
    wire logic [7:0] two_lines;
    wire logic [8:0] two_total;
    wire logic [7:0] three_lines;
    wire logic [14:0] three_start;
    wire logic [14:0] four_start;
    wire logic three_pending;
    wire logic four_pending;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] d;
    logic [17:0] regs [5] = '{18'h20040, 18'h20044, 18'h20048, 18'h2004c, 18'h20050};

    host_master host (.clk_in(clk_in), .waitrequest_in(waitrequest), .readdata_in(readdata),
        .address_out(address), .read_out(read), .write_out(write), .writedata_out(writedata),
        .byteenable_out(byteenable));

    screen_block_layout dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .address_in(address),
        .read_in(read), .write_in(write), .writedata_in(writedata), .byteenable_in(byteenable),
        .readdata_out(readdata), .waitrequest_out(waitrequest), .block_one_lines_in(block_one_lines),
        .smooth_scroll_in(smooth_scroll), .block_two_lines_out(two_lines),
        .block_two_line_total_out(two_total), .block_three_lines_out(three_lines),
        .block_three_start_out(three_start), .block_four_start_out(four_start),
        .block_three_pending_out(three_pending), .block_four_pending_out(four_pending));

    initial
    begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] expected, input logic [31:0] seen);
        comparisons++;
        if (seen !== expected)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, expected, seen);
        end
    endtask

    // Run takes under a hundred cycles; this ceiling only catches a hang
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    initial
    begin
        reset_n_in <= 1'b0;
        block_one_lines <= 8'h00;
        smooth_scroll <= 1'b0;
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            host.bus_read(regs[i], d);
            check("reset value", 32'h00000000, d);
        end
        @(negedge clk_in);
        check("start outputs at reset", 32'h00000000, {2'b00, three_start, four_start});
        check("idle waitrequest", 32'h00000000, {31'h00000000, waitrequest});
        host.bus_write(regs[0], 8'hff, 4'h1);
        @(negedge clk_in);
        check("block two field", 32'h000000ff, {24'h000000, two_lines});
        check("block two total max", 32'h00000100, {23'h000000, two_total});
        @(posedge clk_in);
        block_one_lines <= 8'h20;
        @(posedge clk_in);
        @(negedge clk_in);
        check("block three lines one smaller", 32'h00000020, {24'h000000, three_lines});
        host.bus_write(regs[0], 8'h05, 4'h1);
        @(posedge clk_in);
        @(negedge clk_in);
        check("block three lines two smaller", 32'h00000005, {24'h000000, three_lines});
        check("block two total", 32'h00000006, {23'h000000, two_total});
        host.bus_write(regs[0], 8'haa, 4'h0);
        host.bus_write(18'h20060, 8'h77, 4'h1);
        host.bus_read(regs[0], d);
        check("line count after dropped write", 32'h00000005, d);
        host.bus_read(18'h20060, d);
        check("unmapped read", 32'h00000000, d);
        host.bus_write(regs[1], 8'h34, 4'h1);
        @(negedge clk_in);
        check("block three after low only", 32'h00000000, {17'h00000, three_start});
        host.bus_write(regs[2], 8'h12, 4'h1);
        @(negedge clk_in);
        check("block three applied", 32'h00001234, {17'h00000, three_start});
        host.write_start(regs[3], 8'h78, 8'h56);
        @(negedge clk_in);
        check("block four applied", 32'h00005678, {17'h00000, four_start});
        host.write_start(regs[3], 8'h9a, 8'hc5);
        @(negedge clk_in);
        check("block four held while scroll off", 32'h00005678, {17'h00000, four_start});
        check("block four pending", 32'h00000001, {31'h00000000, four_pending});
        host.bus_read(regs[4], d);
        check("block four high with flag", 32'h000000c5, d);
        @(posedge clk_in);
        smooth_scroll <= 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        check("block four released", 32'h0000459a, {17'h00000, four_start});
        check("block four pending cleared", 32'h00000000, {31'h00000000, four_pending});
        host.write_start(regs[1], 8'h11, 8'h81);
        @(negedge clk_in);
        check("block three during scroll", 32'h00000111, {17'h00000, three_start});
        check("block three not pending", 32'h00000000, {31'h00000000, three_pending});
        host.bus_read(regs[1], d);
        check("block three low readback", 32'h00000011, d);
        tally_and_finish();
    end
endmodule // screen_block_layout_bench
